/* verilog/ref_map_pkg.sv */
package ref_map_pkg;

   // ----------------------------------------------------------------------
   // Bus and widths
   // ----------------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int DUTY_W = 8;
   localparam int REF_W  = 16;

   // ----------------------------------------------------------------------
   // Register byte addresses
   // ----------------------------------------------------------------------
   localparam logic [7:0] CTRL_ADDR   = 8'h00;
   localparam logic [7:0] THR_LO_ADDR = 8'h04;
   localparam logic [7:0] THR_MID_ADDR= 8'h08;
   localparam logic [7:0] THR_HI_ADDR = 8'h0c;
   localparam logic [7:0] LVL_ADDR    = 8'h10;
   localparam logic [7:0] LVL_HI_ADDR = 8'h14;
   localparam logic [7:0] MAX_ADDR    = 8'h18;
   localparam logic [7:0] CEIL_ADDR   = 8'h1c;
   localparam logic [7:0] DUTY_ADDR   = 8'h20;
   localparam logic [7:0] STATUS_ADDR = 8'h24;

   // ----------------------------------------------------------------------
   // Control and status register fields
   // ----------------------------------------------------------------------
   localparam int CTRL_PROFILE_LSB = 0;
   localparam int CTRL_MODE_LSB    = 2;
   localparam int CTRL_STANDBY_BIT = 4;
   localparam int CTRL_DIR_BIT     = 5;
   localparam int CTRL_DIGITAL_BIT = 6;
   localparam int STAT_RUN_BIT     = 24;
   localparam int STAT_REV_BIT     = 25;

   // Profile selection codes
   localparam logic [1:0] PROFILE_BYPASS = 2'h0;
   localparam logic [1:0] PROFILE_FWDREV = 2'h3;

   // Control mode codes
   localparam logic [1:0] MODE_SPEED   = 2'h0;
   localparam logic [1:0] MODE_POWER   = 2'h1;
   localparam logic [1:0] MODE_CURRENT = 2'h2;
   localparam logic [1:0] MODE_MODIDX  = 2'h3;

   // ----------------------------------------------------------------------
   // Scaling
   // ----------------------------------------------------------------------
   localparam int          FULL_CODE     = 255;
   localparam int          MIN_DUTY_PCT  = 1;
   localparam logic [7:0]  MIN_DUTY_CODE = 8'((FULL_CODE * MIN_DUTY_PCT + 99) / 100);
   localparam logic [15:0] MODIDX_FULL   = 16'hffff;
   localparam logic [23:0] FULL_DIV      = 24'(FULL_CODE);

   // ----------------------------------------------------------------------
   // Carrier of the mapped target
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [REF_W-1:0]  target;
      logic [DUTY_W-1:0] ref_x;
      logic [DUTY_W-1:0] mod_duty;
      logic              run;
      logic              reverse;
      logic              valid;
   } target_s;

endpackage

/* verilog/duty_to_reference_mapper.sv */
// Operation
// R1 - Forward-reverse profile ignores direction pin and direction register bit.
// R2 - Command below low off threshold gives the low off level.
// R3 - Hysteresis between off and on thresholds on both low and high ends.
// R4 - Between low off and low clamp thresholds the low clamp level holds.
// R5 - Linear ramp from low clamp threshold to breakpoint A; breakpoints ascend.
// R6 - Level A holds from A to B; above B the motor is off.
// R7 - Crossing breakpoint C reverses the commanded direction.
// R8 - Above D run reverse at level D up to breakpoint E.
// R9 - Ramp from E to high clamp threshold, then high clamp level.
// R10 - Above high off threshold switch to the high off level.
// R11 - Hysteresis width applies at the steps at breakpoints B and D.
// R12 - Speed mode: full command gives maximum speed, scaled linearly.
// R13 - Zero maximum speed or power forces zero reference and stopped motor.
// R14 - Power mode: full command gives maximum power, scaled linearly.
// R15 - Current mode: full command gives the current ceiling.
// R16 - Command or profile output below one percent forces zero and stop; the code only tests the selected reference ref_x.
// R17 - Modulation mode: applied duty proportional to command up to full.
// R18 - Modulation mode below minimum duty drives zero output duty.
// R19 - Target is eight-bit profile output over 255 times full scale.
// R20 - Profile code 11b selects forward-reverse, 00b bypasses the profiler.
// R21 - Zero command: standby runs at low off level, sleep stops.
// R22 - Software programs breakpoints ascending; not checked here.
// R23 - Each control update re-evaluates, hysteresis state kept between updates.
module duty_to_reference_mapper
   import ref_map_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic              rstn,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] wdata,
   input  wire logic              wr,
   input  wire logic              rd,
   output      logic [DATA_W-1:0] rdata,
   input  wire logic [DUTY_W-1:0] duty_cmd,
   input  wire logic              duty_valid,
   input  wire logic              dir_pin,
   output      target_s           result
);

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [6:0]        ctrl;
      logic [31:0]       thr_lo;
      logic [31:0]       thr_mid;
      logic [31:0]       thr_hi;
      logic [31:0]       lvl;
      logic [15:0]       lvl_hi;
      logic [31:0]       max;
      logic [15:0]       ceiling;
      logic [7:0]        dig_duty;
      logic              dir_meta;
      logic              dir_sync;
      logic              low_off;
      logic              high_off;
      logic              past_b;
      logic              past_d;
      logic [7:0]        last_duty;
      target_s           out;
      logic [DATA_W-1:0] rdata;
   } state_s;

   state_s st;
   state_s next_st;

   // ----------------------------------------------------------------------
   // Configuration fields
   // ----------------------------------------------------------------------
   logic [1:0] profile;
   logic [1:0] mode;
   logic       standby;
   logic [7:0] low_off_threshold;
   logic [7:0] low_on_threshold;
   logic [7:0] low_clamp_threshold;
   logic [7:0] bp_a;
   logic [7:0] bp_b;
   logic [7:0] bp_c;
   logic [7:0] bp_d;
   logic [7:0] bp_e;
   logic [7:0] high_clamp_threshold;
   logic [7:0] high_on_threshold;
   logic [7:0] high_off_threshold;
   logic [7:0] command_hysteresis_width;
   logic [7:0] low_off_level;
   logic [7:0] low_clamp_level;
   logic [7:0] level_a;
   logic [7:0] level_d;
   logic [7:0] high_clamp_level;
   logic [7:0] high_off_level;
   logic [15:0] max_speed;
   logic [15:0] max_power;

   assign profile                  = st.ctrl[CTRL_PROFILE_LSB +: 2];
   assign mode                     = st.ctrl[CTRL_MODE_LSB +: 2];
   assign standby                  = st.ctrl[CTRL_STANDBY_BIT];
   assign low_off_threshold        = st.thr_lo[7:0];
   assign low_on_threshold         = st.thr_lo[15:8];
   assign low_clamp_threshold      = st.thr_lo[23:16];
   assign bp_a                     = st.thr_lo[31:24];
   assign bp_b                     = st.thr_mid[7:0];
   assign bp_c                     = st.thr_mid[15:8];
   assign bp_d                     = st.thr_mid[23:16];
   assign bp_e                     = st.thr_mid[31:24];
   assign high_clamp_threshold     = st.thr_hi[7:0];
   assign high_on_threshold        = st.thr_hi[15:8];
   assign high_off_threshold       = st.thr_hi[23:16];
   assign command_hysteresis_width = st.thr_hi[31:24];
   assign low_off_level            = st.lvl[7:0];
   assign low_clamp_level          = st.lvl[15:8];
   assign level_a                  = st.lvl[23:16];
   assign level_d                  = st.lvl[31:24];
   assign high_clamp_level         = st.lvl_hi[7:0];
   assign high_off_level           = st.lvl_hi[15:8];
   assign max_speed                = st.max[15:0];
   assign max_power                = st.max[31:16];

   // ----------------------------------------------------------------------
   // Linear interpolation between two breakpoints
   // ----------------------------------------------------------------------
   function automatic logic [7:0] interp(input logic [7:0] x, input logic [7:0] x0,
                                         input logic [7:0] x1, input logic [7:0] y0,
                                         input logic [7:0] y1);
      logic signed [17:0] num;
      logic signed [17:0] q;
      logic signed [17:0] span;
      num  = 18'(signed'({1'b0, x} - {1'b0, x0})) *
             18'(signed'({1'b0, y1} - {1'b0, y0}));
      span = 18'(signed'({1'b0, x1} - {1'b0, x0}));
      if (x1 <= x0) begin
         q = 18'(signed'({1'b0, y1} - {1'b0, y0}));
      end else begin
         q = num / span;
      end
      interp = 8'(18'(signed'({10'h000, y0})) + q);
   endfunction

   // ----------------------------------------------------------------------
   // Update strobe and command source
   // ----------------------------------------------------------------------
   logic       dig_write;
   logic       upd;
   logic [7:0] duty;

   assign dig_write = wr && (addr == DUTY_ADDR) && st.ctrl[CTRL_DIGITAL_BIT];
   assign upd       = dig_write || (duty_valid && !st.ctrl[CTRL_DIGITAL_BIT]);
   assign duty      = dig_write ? wdata[7:0] : duty_cmd;

   // ----------------------------------------------------------------------
   // Forward-reverse profile
   // ----------------------------------------------------------------------
   logic       n_low_off;
   logic       n_high_off;
   logic       n_past_b;
   logic       n_past_d;
   logic [7:0] fr_ref;
   logic       fr_run;
   logic       fr_rev;

   always_comb begin
      n_low_off  = st.low_off;
      n_high_off = st.high_off;
      n_past_b   = st.past_b;
      n_past_d   = st.past_d;
      if (duty < low_off_threshold) begin
         n_low_off = 1'b1; // R3
      end else if (duty >= low_on_threshold) begin
         n_low_off = 1'b0; // R3
      end
      if (duty > high_off_threshold) begin
         n_high_off = 1'b1; // R3
      end else if (duty < high_on_threshold) begin
         n_high_off = 1'b0; // R3
      end
      if ({1'b0, duty} >= {1'b0, bp_b} + {1'b0, command_hysteresis_width}) begin
         n_past_b = 1'b1; // R11
      end else if (duty < bp_b) begin
         n_past_b = 1'b0; // R11
      end
      if ({1'b0, duty} >= {1'b0, bp_d} + {1'b0, command_hysteresis_width}) begin
         n_past_d = 1'b1; // R11
      end else if (duty < bp_d) begin
         n_past_d = 1'b0; // R11
      end
      fr_rev = duty >= bp_c; // R7
      fr_run = 1'b1;
      if (n_low_off) begin
         fr_ref = low_off_level; // R2
      end else if (duty <= low_clamp_threshold) begin
         fr_ref = low_clamp_level; // R4
      end else if (duty < bp_a) begin
         fr_ref = interp(duty, low_clamp_threshold, bp_a, low_clamp_level, level_a); // R5
      end else if (!n_past_b) begin
         fr_ref = level_a; // R6
      end else if (!n_past_d) begin
         fr_ref = 8'h00; // R6
         fr_run = 1'b0;
      end else if (duty <= bp_e) begin
         fr_ref = level_d; // R8
      end else if (duty < high_clamp_threshold) begin
         fr_ref = interp(duty, bp_e, high_clamp_threshold, level_d, high_clamp_level); // R9
      end else if (!n_high_off) begin
         fr_ref = high_clamp_level; // R9
      end else begin
         fr_ref = high_off_level; // R10
      end
   end

   // ----------------------------------------------------------------------
   // Reference selection and scaling
   // ----------------------------------------------------------------------
   logic [7:0]  ref_x;
   logic        run;
   logic        rev;
   logic [15:0] full;
   logic [23:0] scaled;
   logic [7:0]  bypass_ref;
   logic [8:0]  delta;

   always_comb begin
      delta      = (duty >= st.last_duty) ? {1'b0, duty - st.last_duty}
                                          : {1'b0, st.last_duty - duty};
      bypass_ref = (delta >= {1'b0, command_hysteresis_width}) ? duty : st.last_duty;
      rev        = st.dir_sync | st.ctrl[CTRL_DIR_BIT];
      run        = 1'b1;
      if (profile == PROFILE_FWDREV) begin // R20
         ref_x = fr_ref;
         run   = fr_run;
         rev   = fr_rev; // R1
      end else begin
         ref_x = bypass_ref; // R20
      end
      if (duty == 8'h00) begin
         ref_x = standby ? low_off_level : 8'h00; // R21
         run   = standby;
      end
      unique case (mode)
         MODE_SPEED:   full = max_speed; // R12
         MODE_POWER:   full = max_power; // R14
         MODE_CURRENT: full = st.ceiling; // R15
         MODE_MODIDX:  full = MODIDX_FULL; // R17
      endcase
      if (ref_x < MIN_DUTY_CODE || full == 16'h0000) begin
         run = 1'b0; // R13 R16
      end
      scaled = (24'(ref_x) * 24'(full)) / FULL_DIV; // R19
      if (!run) begin
         scaled = 24'h000000; // R16
      end
   end

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      next_st           = st;
      next_st.dir_meta  = dir_pin;
      next_st.dir_sync  = st.dir_meta;
      next_st.out.valid = 1'b0;
      if (wr) begin
         unique case (addr)
            CTRL_ADDR:    next_st.ctrl    = wdata[6:0];
            THR_LO_ADDR:  next_st.thr_lo  = wdata;
            THR_MID_ADDR: next_st.thr_mid = wdata;
            THR_HI_ADDR:  next_st.thr_hi  = wdata;
            LVL_ADDR:     next_st.lvl     = wdata;
            LVL_HI_ADDR:  next_st.lvl_hi  = wdata[15:0];
            MAX_ADDR:     next_st.max     = wdata;
            CEIL_ADDR:    next_st.ceiling = wdata[15:0];
            DUTY_ADDR:    next_st.dig_duty = wdata[7:0];
            default:      next_st.ctrl    = st.ctrl;
         endcase
      end
      if (upd) begin // R23
         next_st.low_off      = n_low_off;
         next_st.high_off     = n_high_off;
         next_st.past_b       = n_past_b;
         next_st.past_d       = n_past_d;
         next_st.last_duty    = bypass_ref;
         next_st.out.ref_x    = ref_x;
         next_st.out.target   = scaled[15:0];
         next_st.out.mod_duty = (run && mode == MODE_MODIDX) ? ref_x : 8'h00; // R17 R18
         next_st.out.run      = run;
         next_st.out.reverse  = rev;
         next_st.out.valid    = 1'b1;
      end
      next_st.rdata = '0;
      if (rd) begin
         unique case (addr)
            CTRL_ADDR:    next_st.rdata = {25'h0000000, st.ctrl};
            THR_LO_ADDR:  next_st.rdata = st.thr_lo;
            THR_MID_ADDR: next_st.rdata = st.thr_mid;
            THR_HI_ADDR:  next_st.rdata = st.thr_hi;
            LVL_ADDR:     next_st.rdata = st.lvl;
            LVL_HI_ADDR:  next_st.rdata = {16'h0000, st.lvl_hi};
            MAX_ADDR:     next_st.rdata = st.max;
            CEIL_ADDR:    next_st.rdata = {16'h0000, st.ceiling};
            DUTY_ADDR:    next_st.rdata = {24'h000000, st.dig_duty};
            STATUS_ADDR: begin
               next_st.rdata[REF_W-1:0]  = st.out.target;
               next_st.rdata[23:16]      = st.out.ref_x;
               next_st.rdata[STAT_RUN_BIT] = st.out.run;
               next_st.rdata[STAT_REV_BIT] = st.out.reverse;
            end
            default:      next_st.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign rdata  = st.rdata;
   assign result = st.out;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   property p_fr_dir;
      upd && profile == PROFILE_FWDREV |=> result.reverse == ($past(duty) >= $past(bp_c));
   endproperty
   a_fr_dir: assert property (p_fr_dir) else $error("fwd-rev direction wrong"); // R1 R7

   property p_low_off;
      upd && profile == PROFILE_FWDREV && duty != 8'h00 && duty < low_off_threshold
         |=> result.ref_x == $past(low_off_level);
   endproperty
   a_low_off: assert property (p_low_off) else $error("low off level missing"); // R2

   property p_low_hys;
      upd && profile == PROFILE_FWDREV && duty >= low_on_threshold
         && duty >= low_off_threshold |=> !st.low_off;
   endproperty
   a_low_hys: assert property (p_low_hys) else $error("low hysteresis stuck"); // R3

   property p_off_band;
      upd && profile == PROFILE_FWDREV && !n_low_off && duty >= bp_a && n_past_b
         && !n_past_d |=> !result.run && result.target == 16'h0000;
   endproperty
   a_off_band: assert property (p_off_band) else $error("off band drives motor"); // R6

   property p_max_zero;
      upd && ((mode == MODE_SPEED && max_speed == 16'h0000)
         || (mode == MODE_POWER && max_power == 16'h0000)) |=> result.target == 16'h0000;
   endproperty
   a_max_zero: assert property (p_max_zero) else $error("zero max not honoured"); // R13

   property p_min_duty;
      result.run |-> result.ref_x >= MIN_DUTY_CODE;
   endproperty
   a_min_duty: assert property (p_min_duty) else $error("running below min duty"); // R16

   property p_modidx_zero;
      upd && mode == MODE_MODIDX && !run |=> result.mod_duty == 8'h00;
   endproperty
   a_modidx_zero: assert property (p_modidx_zero) else $error("mod duty not zero"); // R18

   property p_speed_scale;
      upd && run && mode == MODE_SPEED
         |=> 24'(result.target) == (24'($past(ref_x)) * 24'($past(max_speed))) / FULL_DIV;
   endproperty
   a_speed_scale: assert property (p_speed_scale) else $error("speed scaling wrong"); // R12 R19

   property p_hold;
      !upd |=> $stable(result.target) && !result.valid;
   endproperty
   a_hold: assert property (p_hold) else $error("target moved without update"); // R23

   property p_sleep_zero;
      upd && duty == 8'h00 && !standby |=> !result.run ##1 1'b1;
   endproperty
   a_sleep_zero: assert property (p_sleep_zero) else $error("sleep zero still runs"); // R21

endmodule // duty_to_reference_mapper

/* test/duty_host_model.sv */
module duty_host_model
   import ref_map_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic              rstn,
   input  wire logic              send,
   input  wire logic [DUTY_W-1:0] send_val,
   input  wire logic              dir_req,
   output      logic [DUTY_W-1:0] duty_cmd,
   output      logic              duty_valid,
   output      logic              dir_pin
);
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic [DUTY_W-1:0] duty;
      logic              vld;
      logic              dir;
   } host_s;

   host_s st;
   host_s next_st;

   // ----------------------------------------------------------------------
   // Host side of the command pin
   // ----------------------------------------------------------------------
   // Outside a strobe the command toggles, so a stale value never looks held
   always_comb begin
      next_st      = st;
      next_st.vld  = send;
      next_st.dir  = dir_req;
      next_st.duty = send ? send_val : ~st.duty;
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign duty_cmd   = st.duty;
   assign duty_valid = st.vld;
   assign dir_pin    = st.dir;

endmodule // duty_host_model

/* test/duty_to_reference_mapper_tb_top.sv */
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
   $display("MISMATCH %0t got %h exp %h", $time, (g), (e)); end end

module duty_to_reference_mapper_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import ref_map_pkg::*;

   typedef struct packed {
      target_s r;
      logic    chk_x;
   } exp_s;

   localparam logic [7:0] FR_D [20] = '{8'h3c, 8'h5a, 8'h68, 8'h6e, 8'h68, 8'h62, 8'h82,
      8'h9b, 8'ha0, 8'h98, 8'hc3, 8'hdc, 8'hf5, 8'heb, 8'he1, 8'h3c, 8'h0f, 8'h05, 8'h0f, 8'h19};
   localparam logic [7:0] FR_X [20] = '{8'h3c, 8'h5a, 8'h5a, 8'h00, 8'h00, 8'h5a, 8'h00,
      8'h00, 8'h3c, 8'h3c, 8'h4b, 8'h5a, 8'h32, 8'h32, 8'h5a, 8'h3c, 8'h1e, 8'h14, 8'h14, 8'h1e};
   localparam logic [19:0] FR_RUN = 20'hfff27;
   localparam logic [19:0] FR_REV = 20'h07fc0;
   localparam logic [15:0] FS [4] = '{16'h03e8, 16'h07d0, 16'h01f4, 16'hffff};
   localparam logic [7:0]  BD [4] = '{8'hff, 8'h03, 8'h02, 8'h80};

   logic              ref_clk = 1'b0;
   logic              rstn = 1'b0;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wdata = '0;
   logic              wr = 1'b0;
   logic              rd = 1'b0;
   logic [DATA_W-1:0] rdata;
   logic [DUTY_W-1:0] duty_cmd;
   logic              duty_valid;
   logic              dir_pin;
   target_s           result;
   logic              send = 1'b0;
   logic [DUTY_W-1:0] send_val = '0;
   logic              dir_req = 1'b0;
   logic              rd_pend = 1'b0;
   int                error_cnt = 0;
   int                tests_run = 0;
   logic [31:0]       seed = 32'd29050;
   exp_s              exp_q[$];
   logic [31:0]       rd_q[$];

   always #2.5 ref_clk = ~ref_clk;

   duty_to_reference_mapper dut (.ref_clk(ref_clk), .rstn(rstn), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .duty_cmd(duty_cmd), .duty_valid(duty_valid),
      .dir_pin(dir_pin), .result(result));

   duty_host_model host (.ref_clk(ref_clk), .rstn(rstn), .send(send), .send_val(send_val),
      .dir_req(dir_req), .duty_cmd(duty_cmd), .duty_valid(duty_valid), .dir_pin(dir_pin));

   // ----------------------------------------------------------------------
   // Bus and update drivers
   // ----------------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge ref_clk);
      wr    <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
      rd_q.push_back(e);
      @(posedge ref_clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge ref_clk);
      rd   <= 1'b0;
   endtask

   task automatic pulse(input logic [7:0] d);
      @(posedge ref_clk);
      send     <= 1'b1;
      send_val <= d;
      @(posedge ref_clk);
      send     <= 1'b0;
   endtask

   task automatic upd(input logic [7:0] d, input logic [7:0] x, input logic rn,
                      input logic rv, input logic [15:0] tg, input logic [7:0] md,
                      input logic dig);
      exp_s e;
      e.r     = '{target: tg, ref_x: x, mod_duty: md, run: rn, reverse: rv, valid: 1'b1};
      e.chk_x = rn;
      exp_q.push_back(e);
      if (dig) begin
         wr_reg(DUTY_ADDR, {24'h0, d});
      end else begin
         pulse(d);
      end
   endtask

   task automatic byp(input logic [7:0] d, input int m, input logic rv);
      logic [15:0] tg;
      tg = (d < MIN_DUTY_CODE) ? 16'h0 : 16'((32'(d) * 32'(FS[m])) / 255);
      upd(d, d, d >= MIN_DUTY_CODE, rv, tg, (m == 3 && d >= MIN_DUTY_CODE) ? d : 8'h0, 1'b0);
   endtask

   // ----------------------------------------------------------------------
   // Output monitor
   // ----------------------------------------------------------------------
   always @(posedge ref_clk) begin
      exp_s e;
      if (rd_pend) begin
         `CHK(rdata, rd_q.pop_front())
      end else if (rstn) begin
         `CHK(rdata, 32'h0)
      end
      rd_pend = rd;
      if (result.valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            error_cnt++;
            $display("MISMATCH %0t unexpected update", $time);
         end else begin
            e = exp_q.pop_front();
            `CHK(result.target, e.r.target)
            `CHK(result.mod_duty, e.r.mod_duty)
            `CHK(result.run, e.r.run)
            `CHK(result.reverse, e.r.reverse)
            if (e.chk_x) `CHK(result.ref_x, e.r.ref_x)
         end
      end
   end

   // ----------------------------------------------------------------------
   // Verdict and watchdog
   // ----------------------------------------------------------------------
   task automatic end_sim();
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge ref_clk);
      error_cnt++;
      end_sim();
   end

   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   initial begin
      repeat (10) @(posedge ref_clk);
      rstn <= 1'b1;
      rd_reg(CTRL_ADDR, 32'h0);
      rd_reg(MAX_ADDR, 32'h0);
      rd_reg(STATUS_ADDR, 32'h0);
      rd_reg(8'h28, 32'h0);
      wr_reg(MAX_ADDR, 32'h07d0_03e8);
      wr_reg(CEIL_ADDR, 32'h0000_01f4);
      for (int m = 0; m < 4; m++) begin
         wr_reg(CTRL_ADDR, 32'(m) << CTRL_MODE_LSB);
         for (int i = 0; i < 4; i++) byp(BD[i], m, 1'b0);
      end
      wr_reg(CTRL_ADDR, 32'h0);
      for (int i = 0; i < 6; i++) begin
         seed = xs(seed);
         byp(8'(3 + seed % 253), 0, 1'b0);
      end
      wr_reg(CTRL_ADDR, 32'h1 << CTRL_DIGITAL_BIT);
      pulse(8'h50);
      upd(8'hc8, 8'hc8, 1'b1, 1'b0, 16'h0310, 8'h0, 1'b1);
      wr_reg(STATUS_ADDR, 32'hffff_ffff);
      rd_reg(STATUS_ADDR, 32'h01c8_0310);
      wr_reg(CTRL_ADDR, 32'h1 << CTRL_DIR_BIT);
      byp(8'h64, 0, 1'b1);
      wr_reg(CTRL_ADDR, 32'h0);
      dir_req <= 1'b1;
      repeat (4) @(posedge ref_clk);
      byp(8'h64, 0, 1'b1);
      wr_reg(MAX_ADDR, 32'h0);
      for (int m = 0; m < 2; m++) begin
         wr_reg(CTRL_ADDR, 32'(m) << CTRL_MODE_LSB);
         upd(8'hc8, 8'hc8, 1'b0, 1'b1, 16'h0, 8'h0, 1'b0);
      end
      // Breakpoints ascend as software must program them
      wr_reg(THR_LO_ADDR, 32'h5028_140a);
      wr_reg(THR_MID_ADDR, 32'hb496_8064);
      wr_reg(THR_HI_ADDR, 32'h08f0_e6d2);
      wr_reg(LVL_ADDR, 32'h3c5a_1e14);
      wr_reg(LVL_HI_ADDR, 32'h0000_325a);
      wr_reg(MAX_ADDR, 32'h0000_00ff);
      rd_reg(THR_MID_ADDR, 32'hb496_8064);
      wr_reg(CTRL_ADDR, 32'(PROFILE_FWDREV) | (32'h1 << CTRL_DIR_BIT));
      for (int i = 0; i < 20; i++) begin
         upd(FR_D[i], FR_X[i], FR_RUN[i], FR_REV[i], FR_RUN[i] ? 16'(FR_X[i]) : 16'h0, 8'h0,
             1'b0);
      end
      upd(8'h00, 8'h00, 1'b0, 1'b0, 16'h0, 8'h0, 1'b0);
      wr_reg(CTRL_ADDR, 32'(PROFILE_FWDREV) | (32'h1 << CTRL_STANDBY_BIT));
      upd(8'h00, 8'h14, 1'b1, 1'b0, 16'h0014, 8'h0, 1'b0);
      // Bypass with a nonzero width: a step smaller than the width is held
      wr_reg(CTRL_ADDR, 32'h0);
      upd(8'h64, 8'h64, 1'b1, 1'b1, 16'h0064, 8'h0, 1'b0);
      upd(8'h6a, 8'h64, 1'b1, 1'b1, 16'h0064, 8'h0, 1'b0);
      repeat (10) @(posedge ref_clk);
      `CHK(exp_q.size(), 0)
      end_sim();
   end

endmodule // duty_to_reference_mapper_tb_top
